// ==== rtl/frc_consts.vh ====
`ifndef FRC_CONSTS_VH
`define FRC_CONSTS_VH

// ============================================================
// Register map (byte addresses on the AXI4-Lite bus)
`define FRC_ADDR_CTRL 8'h00
`define FRC_ADDR_STATUS 8'h04
`define FRC_ADDR_OFFSETS 8'h08
`define FRC_ADDR_POINTERS 8'h0c

// ============================================================
// Field positions
`define FRC_CTRL_SOFT_PRS 0
`define FRC_ST_FFIR 0
`define FRC_ST_EFOR 1
`define FRC_ST_AE 2
`define FRC_ST_AF 3
`define FRC_ST_MAILBOX_ONE_FLAG 4
`define FRC_ST_MAILBOX_TWO_FLAG 5
`define FRC_ST_BIG_ENDIAN 6
`define FRC_ST_STD_TIMING 7
`define FRC_ST_PROG_LO 8
`define FRC_ST_INCOMPLETE 11
`define FRC_ST_STATE_LO 12

// ============================================================
// Timing counts, in port clock edges
`define FRC_RESET_EDGES 3'd4
`define FRC_READY_EDGES 2'd2

// ============================================================
// Offset programming methods
`define FRC_PROG_PRESET64 3'd0
`define FRC_PROG_PRESET16 3'd1
`define FRC_PROG_PRESET8 3'd2
`define FRC_PROG_PARALLEL 3'd3
`define FRC_PROG_SERIAL 3'd4
`define FRC_PROG_RESERVED 3'd5

// ============================================================
// Preset offsets and reset values
`define FRC_OFS_64 10'h040
`define FRC_OFS_16 10'h010
`define FRC_OFS_8 10'h008
`define FRC_OFS_RESET 10'h040
`define FRC_RESP_OKAY 2'b00
`define FRC_RESP_SLVERR 2'b10

`endif

// ==== rtl/frc_pin_sync.v ====
`timescale 1ns/1ps
// ============================================================
// Two-flop synchroniser with rising-edge pulse per bit
module frc_pin_sync #(
  parameter WIDTH = 20
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Pins
  input wire [WIDTH-1:0] pin_in,
  // Synchronised level and rising-edge pulse
  output reg [WIDTH-1:0] level_q,
  output reg [WIDTH-1:0] rise_q
);

  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] prev_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= {WIDTH{1'b0}};
      level_q <= {WIDTH{1'b0}};
      prev_q <= {WIDTH{1'b0}};
      rise_q <= {WIDTH{1'b0}};
    end else begin
      meta_q <= pin_in;
      level_q <= meta_q;
      prev_q <= level_q;
      rise_q <= level_q & ~prev_q;
    end
  end

endmodule // frc_pin_sync

// ==== rtl/frc_reset_ctrl.v ====
`timescale 1ns/1ps
`include "frc_consts.vh"
module frc_reset_ctrl (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Port clock pins, sampled
  input wire write_port_clock,
  input wire read_port_clock,
  // Reset pins
  input wire primary_reset_n,
  input wire secondary_reset_n,
  input wire partial_reset_n,
  // Configuration pins
  input wire byte_order_timing_select,
  input wire flag_select_low,
  input wire flag_select_high,
  input wire serial_program_mode_n,
  // Write port for offset loading
  input wire write_enable,
  input wire [9:0] write_data,
  // Flags
  output reg full_or_input_ready,
  output reg empty_or_output_ready,
  output reg almost_empty_flag,
  output reg almost_full_flag,
  output reg mailbox_one_flag,
  output reg mailbox_two_flag,
  // AXI4-Lite write
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  localparam ST_HOLD = 2'd0;
  localparam ST_WAIT = 2'd1;
  localparam ST_RUN = 2'd2;
  localparam ST_STALL = 2'd3;

  // ============================================================
  // Decoding helpers
  function [2:0] decode_prog;
    input mode_n;
    input fs_hi;
    input fs_lo;
    begin
      case ({mode_n, fs_hi, fs_lo})
        3'b111: decode_prog = `FRC_PROG_PRESET64;
        3'b110: decode_prog = `FRC_PROG_PRESET16;
        3'b101: decode_prog = `FRC_PROG_PRESET8;
        3'b100: decode_prog = `FRC_PROG_PARALLEL;
        3'b010: decode_prog = `FRC_PROG_SERIAL;
        default: decode_prog = `FRC_PROG_RESERVED;
      endcase
    end
  endfunction

  function addr_ok;
    input [7:0] addr;
    begin
      addr_ok = (addr == `FRC_ADDR_CTRL) || (addr == `FRC_ADDR_STATUS) ||
                (addr == `FRC_ADDR_OFFSETS) || (addr == `FRC_ADDR_POINTERS);
    end
  endfunction

  // ============================================================
  // Pin synchronisers
  wire [19:0] pin_level;
  wire [19:0] pin_rise;

  frc_pin_sync #(.WIDTH(20)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in({write_data, write_enable, serial_program_mode_n, flag_select_high,
             flag_select_low, byte_order_timing_select, partial_reset_n,
             secondary_reset_n, primary_reset_n, read_port_clock, write_port_clock}),
    .level_q(pin_level),
    .rise_q(pin_rise)
  );

  wire wedge = pin_rise[0];
  wire redge = pin_rise[1];
  wire prim_n = pin_level[2];
  wire sec_n = pin_level[3];
  wire part_n = pin_level[4];
  wire bots = pin_level[5];
  wire fs_lo = pin_level[6];
  wire fs_hi = pin_level[7];
  wire spm_n = pin_level[8];
  wire wen = pin_level[9];
  wire [9:0] wdat = pin_level[19:10];

  // ============================================================
  // State
  reg [1:0] state_q;
  reg [2:0] wcnt_q;
  reg [2:0] rcnt_q;
  reg prim_seen_q;
  reg [1:0] rdy_cnt_q;
  reg [1:0] load_cnt_q;
  reg [9:0] wr_ptr_q;
  reg [9:0] rd_ptr_q;
  reg big_endian_q;
  reg [2:0] prog_q;
  reg [9:0] ae_ofs_q;
  reg [9:0] af_ofs_q;
  reg pend_w_q;
  reg pend_r_q;
  reg tm_w_q;
  reg tm_r_q;
  reg soft_prs_q;

  wire part_act = ~part_n | soft_prs_q;
  wire any_act = ~prim_n | part_act;
  wire complete = (wcnt_q >= `FRC_RESET_EDGES) && (rcnt_q >= `FRC_RESET_EDGES);
  wire [2:0] new_prog = decode_prog(spm_n, fs_hi, fs_lo);

  // ============================================================
  // Reset sequencing
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_HOLD;
      wcnt_q <= 3'd0;
      rcnt_q <= 3'd0;
      prim_seen_q <= 1'b0;
      rdy_cnt_q <= 2'd0;
      load_cnt_q <= 2'd2;
      wr_ptr_q <= 10'h000;
      rd_ptr_q <= 10'h000;
      big_endian_q <= 1'b0;
      prog_q <= `FRC_PROG_PRESET64;
      ae_ofs_q <= `FRC_OFS_RESET;
      af_ofs_q <= `FRC_OFS_RESET;
      pend_w_q <= 1'b0;
      pend_r_q <= 1'b0;
      tm_w_q <= 1'b1;
      tm_r_q <= 1'b1;
      full_or_input_ready <= 1'b0;
      empty_or_output_ready <= 1'b0;
      almost_empty_flag <= 1'b0;
      almost_full_flag <= 1'b1;
      mailbox_one_flag <= 1'b1;
      mailbox_two_flag <= 1'b1;
    end else begin
      if (~prim_n | part_act)
        mailbox_one_flag <= 1'b1;
      if (~sec_n | part_act)
        mailbox_two_flag <= 1'b1;
      // Timing mode is sampled on the first edge of each clock after a primary reset release
      if (pend_w_q && wedge && !any_act) begin
        tm_w_q <= bots;
        pend_w_q <= 1'b0;
      end
      if (pend_r_q && redge && !any_act) begin
        tm_r_q <= bots;
        pend_r_q <= 1'b0;
      end
      if (any_act) begin
        // Forced flags while the primary or partial reset is active
        state_q <= ST_HOLD;
        full_or_input_ready <= 1'b0;
        empty_or_output_ready <= 1'b0;
        almost_empty_flag <= 1'b0;
        almost_full_flag <= 1'b1;
        if (state_q != ST_HOLD) begin
          wcnt_q <= 3'd0;
          rcnt_q <= 3'd0;
          prim_seen_q <= ~prim_n;
        end else begin
          if (wedge && wcnt_q < `FRC_RESET_EDGES)
            wcnt_q <= wcnt_q + 3'd1;
          if (redge && rcnt_q < `FRC_RESET_EDGES)
            rcnt_q <= rcnt_q + 3'd1;
          if (~prim_n)
            prim_seen_q <= 1'b1;
        end
      end else begin
        case (state_q)
          ST_HOLD: begin
            wcnt_q <= 3'd0;
            rcnt_q <= 3'd0;
            rdy_cnt_q <= 2'd0;
            if (complete) begin
              wr_ptr_q <= 10'h000;
              rd_ptr_q <= 10'h000;
              state_q <= ST_WAIT;
              load_cnt_q <= 2'd2;
              if (prim_seen_q) begin
                big_endian_q <= bots;
                prog_q <= new_prog;
                pend_w_q <= 1'b1;
                pend_r_q <= 1'b1;
                case (new_prog)
                  `FRC_PROG_PRESET64: begin
                    ae_ofs_q <= `FRC_OFS_64;
                    af_ofs_q <= `FRC_OFS_64;
                  end
                  `FRC_PROG_PRESET16: begin
                    ae_ofs_q <= `FRC_OFS_16;
                    af_ofs_q <= `FRC_OFS_16;
                  end
                  `FRC_PROG_PRESET8: begin
                    ae_ofs_q <= `FRC_OFS_8;
                    af_ofs_q <= `FRC_OFS_8;
                  end
                  `FRC_PROG_PARALLEL: load_cnt_q <= 2'd0;
                  default: load_cnt_q <= 2'd2;
                endcase
              end
            end else begin
              state_q <= ST_STALL;
            end
          end
          ST_WAIT: begin
            if (wedge) begin
              if (rdy_cnt_q == `FRC_READY_EDGES - 2'd1) begin
                full_or_input_ready <= 1'b1;
                state_q <= ST_RUN;
              end
              rdy_cnt_q <= rdy_cnt_q + 2'd1;
            end
          end
          ST_RUN: begin
            if (wedge && wen) begin
              if (load_cnt_q == 2'd0)
                af_ofs_q <= wdat;
              else if (load_cnt_q == 2'd1)
                ae_ofs_q <= wdat;
              else
                wr_ptr_q <= wr_ptr_q + 10'h001;
              if (load_cnt_q != 2'd2)
                load_cnt_q <= load_cnt_q + 2'd1;
            end
          end
          ST_STALL: state_q <= ST_STALL;
          default: state_q <= ST_HOLD;
        endcase
      end
    end
  end

  // ============================================================
  // Register read data
  reg [31:0] rd_mux;

  always @* begin
    rd_mux = 32'h0000_0000;
    case (s_axi_araddr)
      `FRC_ADDR_CTRL: rd_mux[`FRC_CTRL_SOFT_PRS] = soft_prs_q;
      `FRC_ADDR_STATUS: begin
        rd_mux[`FRC_ST_FFIR] = full_or_input_ready;
        rd_mux[`FRC_ST_EFOR] = empty_or_output_ready;
        rd_mux[`FRC_ST_AE] = almost_empty_flag;
        rd_mux[`FRC_ST_AF] = almost_full_flag;
        rd_mux[`FRC_ST_MAILBOX_ONE_FLAG] = mailbox_one_flag;
        rd_mux[`FRC_ST_MAILBOX_TWO_FLAG] = mailbox_two_flag;
        rd_mux[`FRC_ST_BIG_ENDIAN] = big_endian_q;
        rd_mux[`FRC_ST_STD_TIMING] = tm_w_q & tm_r_q;
        rd_mux[`FRC_ST_PROG_LO +: 3] = prog_q;
        rd_mux[`FRC_ST_INCOMPLETE] = (state_q == ST_STALL);
        rd_mux[`FRC_ST_STATE_LO +: 2] = state_q;
      end
      `FRC_ADDR_OFFSETS: rd_mux = {6'h00, af_ofs_q, 6'h00, ae_ofs_q};
      `FRC_ADDR_POINTERS: rd_mux = {6'h00, rd_ptr_q, 6'h00, wr_ptr_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // ============================================================
  // AXI4-Lite slave
  reg have_aw_q;
  reg have_w_q;
  reg [7:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `FRC_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `FRC_RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      have_aw_q <= 1'b0;
      have_w_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      soft_prs_q <= 1'b0;
    end else begin
      if (s_axi_awready && s_axi_awvalid) begin
        have_aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (!have_aw_q && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wready && s_axi_wvalid) begin
        have_w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (!have_w_q && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      if (have_aw_q && have_w_q && !s_axi_bvalid) begin
        have_aw_q <= 1'b0;
        have_w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_ok(awaddr_q) ? `FRC_RESP_OKAY : `FRC_RESP_SLVERR;
        // Soft partial reset is held while the bit stays set
        if (awaddr_q == `FRC_ADDR_CTRL && wstrb_q[0])
          soft_prs_q <= wdata_q[`FRC_CTRL_SOFT_PRS];
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arready && s_axi_arvalid) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= addr_ok(s_axi_araddr) ? `FRC_RESP_OKAY : `FRC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // frc_reset_ctrl

// ==== testbench/frc_host_model.sv ====
`timescale 1ns/1ps
// ============================================================
// Host side: free-running port clocks and reset pulses
module frc_host_model #(
  parameter [3:0] WH = 4'd4,
  parameter [3:0] RH = 4'd5
) (
  // Clock
  input wire aclk,
  // Pulse request
  input wire go,
  input wire [1:0] kind,
  input wire [3:0] n_w,
  input wire [3:0] n_r,
  output reg done,
  // Pins
  output reg write_port_clock,
  output reg read_port_clock,
  output reg primary_reset_n,
  output reg secondary_reset_n,
  output reg partial_reset_n
);
  reg [3:0] wd_q, rd_q, cw_q, cr_q, hold_q;
  reg busy_q;
  initial begin
    {wd_q, rd_q, cw_q, cr_q, hold_q, busy_q, done} = 0;
    {write_port_clock, read_port_clock} = 2'b00;
    {primary_reset_n, secondary_reset_n, partial_reset_n} = 3'b111;
  end
  always @(posedge aclk) begin
    wd_q <= (wd_q == WH - 4'd1) ? 4'd0 : wd_q + 4'd1;
    rd_q <= (rd_q == RH - 4'd1) ? 4'd0 : rd_q + 4'd1;
    if (wd_q == WH - 4'd1) write_port_clock <= !write_port_clock;
    if (rd_q == RH - 4'd1) read_port_clock <= !read_port_clock;
    done <= 1'b0;
    if (go && !busy_q) begin
      {busy_q, cw_q, cr_q, hold_q} <= {1'b1, 12'h0};
      primary_reset_n <= !kind[0];
      secondary_reset_n <= !kind[0];
      partial_reset_n <= !kind[1];
    end else if (busy_q) begin
      // Rising edges seen while the pins are low
      if (wd_q == WH - 4'd1 && !write_port_clock) cw_q <= cw_q + 4'd1;
      if (rd_q == RH - 4'd1 && !read_port_clock) cr_q <= cr_q + 4'd1;
      if (cw_q >= n_w && cr_q >= n_r) hold_q <= hold_q + 4'd1;
      if (hold_q == 4'd6) begin
        {primary_reset_n, secondary_reset_n, partial_reset_n} <= 3'b111;
        busy_q <= 1'b0;
        done <= 1'b1;
      end
    end
  end
endmodule // frc_host_model

// ==== testbench/frc_reset_ctrl_monitor.sv ====
`timescale 1ns/1ps
// ============================================================
// Checker on the top-level ports
module frc_reset_ctrl_monitor (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Reset pins
  input wire primary_reset_n,
  input wire secondary_reset_n,
  input wire partial_reset_n,
  // Flags
  input wire full_or_input_ready,
  input wire empty_or_output_ready,
  input wire almost_empty_flag,
  input wire almost_full_flag,
  input wire mailbox_one_flag,
  input wire mailbox_two_flag,
  // Register bus
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire [1:0] s_axi_bresp,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire [1:0] s_axi_rresp,
  input wire [31:0] s_axi_rdata
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_wr_resp;
    ##[1:2] s_axi_bvalid;
  endsequence
  a_full_flags:
  assert property ($fell(primary_reset_n) |-> ##[1:6] (almost_full_flag && mailbox_one_flag
    && !full_or_input_ready && !empty_or_output_ready)) else $error("full reset flags wrong");
  a_second_mailbox:
  assert property ($fell(secondary_reset_n) |-> ##[1:6] mailbox_two_flag)
    else $error("second mailbox flag not forced");
  a_partial_flags:
  assert property ($fell(partial_reset_n) |-> ##[1:6] (almost_full_flag && !almost_empty_flag
    && mailbox_one_flag && mailbox_two_flag && !full_or_input_ready)) else $error("partial flags");
  a_ready_held_low:
  assert property ((!(primary_reset_n && partial_reset_n)) [*8] |-> !full_or_input_ready)
    else $error("ready high during reset");
  a_ready_late:
  assert property ($rose(full_or_input_ready) |-> $past(primary_reset_n, 6)
    && $past(partial_reset_n, 6)) else $error("ready rose too soon after release");
  a_read_answer:
  assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_bad_read:
  assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h0c
    |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0) else $error("unmapped read answer");
  a_write_answer:
  assert property (s_wr_taken |-> s_wr_resp) else $error("write answer late");
  a_bad_write:
  assert property (s_wr_taken and (s_axi_awaddr > 8'h0c) |-> ##[1:2]
    (s_axi_bvalid && s_axi_bresp == 2'b10)) else $error("unmapped write answer");
endmodule // frc_reset_ctrl_monitor

bind frc_reset_ctrl frc_reset_ctrl_monitor u_mon (
  .aclk(aclk), .aresetn(aresetn), .primary_reset_n(primary_reset_n),
  .secondary_reset_n(secondary_reset_n), .partial_reset_n(partial_reset_n),
  .full_or_input_ready(full_or_input_ready), .empty_or_output_ready(empty_or_output_ready),
  .almost_empty_flag(almost_empty_flag), .almost_full_flag(almost_full_flag),
  .mailbox_one_flag(mailbox_one_flag), .mailbox_two_flag(mailbox_two_flag),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bresp(s_axi_bresp), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rresp(s_axi_rresp),
  .s_axi_rdata(s_axi_rdata)
);

// ==== testbench/frc_reset_ctrl_tb_top.sv ====
`timescale 1ns/1ps
module frc_reset_ctrl_tb_top;
  reg aclk, aresetn, byte_order_timing_select, flag_select_low, flag_select_high;
  reg serial_program_mode_n, write_enable, go, r;
  reg [9:0] write_data;
  reg [1:0] kind, rsp;
  reg [3:0] n_w, n_r, s_axi_wstrb;
  reg [7:0] s_axi_awaddr, s_axi_araddr;
  reg [31:0] s_axi_wdata, rd;
  reg s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  wire write_port_clock, read_port_clock, primary_reset_n, secondary_reset_n;
  wire partial_reset_n, done, full_or_input_ready, empty_or_output_ready;
  wire almost_empty_flag, almost_full_flag, mailbox_one_flag, mailbox_two_flag;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  integer n_mismatch, samples_checked, m;
  frc_reset_ctrl u_dut (
    .aclk(aclk), .aresetn(aresetn),
    .write_port_clock(write_port_clock), .read_port_clock(read_port_clock),
    .primary_reset_n(primary_reset_n), .secondary_reset_n(secondary_reset_n),
    .partial_reset_n(partial_reset_n), .byte_order_timing_select(byte_order_timing_select),
    .flag_select_low(flag_select_low), .flag_select_high(flag_select_high),
    .serial_program_mode_n(serial_program_mode_n), .write_enable(write_enable),
    .write_data(write_data), .full_or_input_ready(full_or_input_ready),
    .empty_or_output_ready(empty_or_output_ready), .almost_empty_flag(almost_empty_flag),
    .almost_full_flag(almost_full_flag), .mailbox_one_flag(mailbox_one_flag),
    .mailbox_two_flag(mailbox_two_flag), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready)
  );
  frc_host_model u_host (
    .aclk(aclk), .go(go), .kind(kind), .n_w(n_w), .n_r(n_r), .done(done),
    .write_port_clock(write_port_clock), .read_port_clock(read_port_clock),
    .primary_reset_n(primary_reset_n), .secondary_reset_n(secondary_reset_n),
    .partial_reset_n(partial_reset_n)
  );
  initial begin
    aclk = 0;
    forever #4 aclk = ~aclk;
  end
  // ============================================================
  // Shared tasks
  task check(input [31:0] exp, input [31:0] got, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task summarize;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task axi_wr(input [7:0] a, input [31:0] d);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'b111};
    rsp = 2'b01;
    while (rsp === 2'b01) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) {rsp, s_axi_bready} <= {s_axi_bresp, 1'b0};
      #1;
    end
  endtask
  task axi_rd(input [7:0] a);
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
    rsp = 2'b01;
    while (rsp === 2'b01) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) {rsp, rd, s_axi_rready} <= {s_axi_rresp, s_axi_rdata, 1'b0};
      #1;
    end
  endtask
  task pulse_rst(input [1:0] k, input [3:0] nw, input [3:0] nr);
    integer i;
    @(posedge aclk);
    {kind, n_w, n_r, go} <= {k, nw, nr, 1'b1};
    @(posedge aclk);
    go <= 1'b0;
    while (done !== 1'b1) @(posedge aclk);
    repeat (4) @(posedge aclk);
    check(0, full_or_input_ready, "ready just after release");
    for (i = 0; i < 80 && full_or_input_ready !== 1'b1; i++) @(posedge aclk);
    r = full_or_input_ready;
  endtask
  task wfall;
    while (write_port_clock !== 1'b1) @(posedge aclk);
    while (write_port_clock !== 1'b0) @(posedge aclk);
  endtask
  function [2:0] exp_prog(input [2:0] c);
    case (c)
      3'b111: exp_prog = 3'd0;
      3'b110: exp_prog = 3'd1;
      3'b101: exp_prog = 3'd2;
      3'b100: exp_prog = 3'd3;
      3'b010: exp_prog = 3'd4;
      default: exp_prog = 3'd5;
    endcase
  endfunction
  // ============================================================
  // Scenarios
  task t_axi;
    axi_wr(8'h00, 32'h1);
    axi_rd(8'h00);
    check(1, rd[0], "soft partial bit");
    axi_wr(8'h00, 32'h0);
    axi_rd(8'h40);
    check(2, rsp, "unmapped read response");
    check(0, rd, "unmapped read data");
    axi_wr(8'h44, 32'h5);
    check(2, rsp, "unmapped write");
  endtask
  task t_short;
    // One edge of each clock plus a short hold stays well under four edges
    pulse_rst(2'b01, 4'd1, 4'd1);
    check(0, r, "ready after short reset");
    axi_rd(8'h04);
    check(1, rd[11], "incomplete flag");
  endtask
  task t_modes;
    for (m = 0; m < 8; m++) begin
      @(posedge aclk);
      {serial_program_mode_n, flag_select_high, flag_select_low} <= m[2:0];
      byte_order_timing_select <= m[1];
      pulse_rst(2'b01, 4'd4, 4'd4);
      if (exp_prog(m[2:0]) != 3'd5) check(1, r, "ready after reset");
      axi_rd(8'h04);
      check({exp_prog(m[2:0]), m[1], m[1], 2'b11}, rd[10:4], "status mode");
      if (m >= 5) begin
        axi_rd(8'h08);
        check({2{6'h0, 10'h008 << (m == 6 ? 1 : m == 7 ? 3 : 0)}}, rd, "preset offsets");
      end
    end
  endtask
  task t_parallel;
    @(posedge aclk);
    {serial_program_mode_n, flag_select_high, flag_select_low} <= 3'b100;
    byte_order_timing_select <= 1'b1;
    pulse_rst(2'b01, 4'd4, 4'd4);
    wfall;
    {write_enable, write_data} <= {1'b1, 10'h123};
    wfall;
    write_data <= 10'h045;
    wfall;
    write_data <= 10'h3ff;
    wfall;
    write_enable <= 1'b0;
    axi_rd(8'h08);
    check(32'h01230045, rd, "loaded offsets");
    axi_rd(8'h0c);
    check(1, rd[9:0], "write pointer after data");
    @(posedge aclk);
    {serial_program_mode_n, flag_select_high, flag_select_low} <= 3'b111;
    byte_order_timing_select <= 1'b0;
    pulse_rst(2'b10, 4'd4, 4'd4);
    check(1, r, "ready after partial");
    axi_rd(8'h08);
    check(32'h01230045, rd, "offsets kept");
    axi_rd(8'h04);
    check(5'b01111, rd[10:6], "config kept");
    axi_rd(8'h0c);
    check(0, rd, "pointers cleared");
  endtask
  initial begin
    {aresetn, byte_order_timing_select, flag_select_low, flag_select_high} = 0;
    {serial_program_mode_n, write_enable, go, write_data, kind, n_w, n_r} = 0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = 0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
    s_axi_wstrb = 4'hf;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_modes;
    t_short;
    t_axi;
    t_parallel;
    summarize;
  end
  initial begin
    #200000;
    n_mismatch++;
    summarize;
  end
endmodule // frc_reset_ctrl_tb_top
